// ==== pkg/fbc_defs.svh ====
// Constants of the framebuffer clear and accumulation engine.
// Assumes nothing; holds definitions only and is included by bare name.
`ifndef FBC_DEFS_SVH
`define FBC_DEFS_SVH
`define FBC_FX_W          16
`define FBC_FX_FRAC       14
`define FBC_FX_ONE        16'h4000
`define FBC_FX_NEG_ONE    16'hC000
`define FBC_FX_ZERO       16'h0000
`define FBC_FX_SAT_HI     32'sh00007FFF
`define FBC_FX_SAT_LO     32'shFFFF8000
`define FBC_IDX_FRAC      8
`define FBC_MASK_COLOR    0
`define FBC_MASK_ACCUM    1
`define FBC_MASK_DEPTH    2
`define FBC_MASK_STENCIL  3
`define FBC_MASK_LEGAL    32'h0000000F
`define FBC_TGT_W         7
`define FBC_TGT_COLOR     0
`define FBC_TGT_ACCUM     1
`define FBC_TGT_DEPTH     2
`define FBC_TGT_STENCIL   3
`define FBC_TGT_MS_COLOR  4
`define FBC_TGT_MS_DEPTH  5
`define FBC_TGT_MS_STENCIL 6
`define FBC_RST_DEPTH     `FBC_FX_ONE
`endif

// ==== pkg/fbc_pkg.sv ====
// Types of the framebuffer clear and accumulation engine.
// Assumes the engine imports it whole.
`default_nettype none
package fbc_pkg;
    typedef enum logic [3:0] {
        FBC_CMD_SET_COLOR       = 4'h0,
        FBC_CMD_SET_INDEX_CLEAR_VALUE = 4'h1,
        FBC_CMD_SET_DEPTH_CLEAR_VALUE = 4'h2,
        FBC_CMD_SET_STENCIL_CLEAR_VALUE = 4'h3,
        FBC_CMD_SET_ACCUMULATOR_CLEAR_VALUE = 4'h4,
        FBC_CMD_CLEAR           = 4'h5,
        FBC_CMD_CLR_BUF_COLOR   = 4'h6,
        FBC_CMD_CLR_BUF_DEPTH   = 4'h7,
        FBC_CMD_CLR_BUF_STENCIL = 4'h8,
        FBC_CMD_CLEAR_DEPTH_STENCIL_PAIR = 4'h9,
        FBC_CMD_ACCUM           = 4'hA
    } fbc_cmd_t;
    typedef enum logic [2:0] {
        FBC_ACC_ACCUM    = 3'h0,
        FBC_ACC_LOAD     = 3'h1,
        FBC_ACC_RETURN   = 3'h2,
        FBC_ACC_OP_SCALE = 3'h3,
        FBC_ACC_ADD      = 3'h4
    } fbc_acc_op_t;
    typedef enum logic [1:0] {
        FBC_FMT_UNORM = 2'h0,
        FBC_FMT_SNORM = 2'h1,
        FBC_FMT_INT   = 2'h2,
        FBC_FMT_FLOAT = 2'h3
    } fbc_fmt_t;
    typedef enum logic [2:0] {
        FBC_ST_IDLE = 3'h0,
        FBC_ST_PIX  = 3'h1,
        FBC_ST_RD   = 3'h3,
        FBC_ST_WR   = 3'h2,
        FBC_ST_NEXT = 3'h6,
        FBC_ST_DONE = 3'h4
    } fbc_state_t;
endpackage
`default_nettype wire

// ==== hdl/fbc_engine.sv ====
// Framebuffer clear and accumulation engine: clear-value state, clears and
// accumulation operations, walked pixel by pixel over the storage port.
// Assumes one clock, storage answering on that clock, synchronous reset.
`timescale 1ns/1ns
`default_nettype none
`include "fbc_defs.svh"

// Summary of operation
// R1: Clear mask bits: colour, accum, depth, stencil; others are a value error.
// R2: Index clear value is fixed point, integer part masked to index bits.
// R3: Depth clear value clamps to [0,1]; only fixed storage converts it.
// R4: Stencil clear value keeps as many low bits as stencil planes.
// R5: Accum clear components clamp to [-1,1] when set.
// R6: Clears apply only ownership, scissor, dither and write masks.
// R7: Clearing a missing buffer changes nothing, no error.
// R8: Unorm colour clamps to [0,1], snorm to [-1,1]; integer undefined.
// R9: Reset clear values are zero, except depth one.
// R10: Per-buffer colour clear clears every physical buffer of one draw buffer.
// R11: Bad per-buffer index is a value error.
// R12: Depth-stencil pair equals separate depth and stencil clears.
// R13: Unconvertible value types give undefined data, never an error.
// R14: Per-buffer colour clear in index mode is an operation error.
// R15: Colour clears clear colour samples, unless draw selection is none; per-buffer colour clears ignore draw_none.
// R16: Depth and stencil clears also clear their samples.
// R17: With scissor on, accumulation touches only the scissor box.
// R18: Accumulate adds scaled read colour, taken as unsigned normalized.
// R19: Load stores scaled read colour instead of adding it.
// R20: Return scales, clamps if enabled, and writes colour.
// R21: Scale multiplies stored values by the operand; add adds it.
// R22: Accumulation without storage, split bindings or index mode is an error.
// R23: Clear and accumulate jobs walk every pixel and report done after the last write; other commands report done at once.
module fbc_engine #(
    parameter int CW       = 8,
    parameter int DW       = 24,
    parameter int SW       = 8,
    parameter int IDXW     = 8,
    parameter int MAX_DRAW = 8,
    parameter int XW       = 12,
    parameter int DBW      = (MAX_DRAW > 1) ? $clog2(MAX_DRAW) : 1
)(
    input  wire logic                      sys_clk,
    input  wire logic                      rst,
    input  wire logic                      cmd_valid,
    output logic                           cmd_ready,
    input  wire fbc_pkg::fbc_cmd_t         cmd_op,
    input  wire fbc_pkg::fbc_acc_op_t      cmd_acc_op,
    input  wire logic [31:0]               cmd_mask,
    input  wire logic [31:0]               cmd_draw_index,
    input  wire logic signed [`FBC_FX_W-1:0] cmd_r,
    input  wire logic signed [`FBC_FX_W-1:0] cmd_g,
    input  wire logic signed [`FBC_FX_W-1:0] cmd_b,
    input  wire logic signed [`FBC_FX_W-1:0] cmd_a,
    input  wire logic [31:0]               cmd_int,
    output logic                           done,
    output logic                           err_value,
    output logic                           err_operation,
    output logic                           err_enum,
    input  wire logic                      has_color,
    input  wire logic                      has_accum,
    input  wire logic                      has_depth,
    input  wire logic                      has_stencil,
    input  wire logic                      has_ms,
    input  wire logic                      depth_is_float,
    input  wire fbc_pkg::fbc_fmt_t         color_fmt,
    input  wire logic                      index_mode,
    input  wire logic                      draw_none,
    input  wire logic                      same_fb,
    input  wire logic                      frag_clamp_en,
    input  wire logic                      scissor_en,
    input  wire logic                      dither_en,
    input  wire logic [XW-1:0]             sc_x,
    input  wire logic [XW-1:0]             sc_y,
    input  wire logic [XW-1:0]             sc_w,
    input  wire logic [XW-1:0]             sc_h,
    input  wire logic [XW-1:0]             win_w,
    input  wire logic [XW-1:0]             win_h,
    input  wire logic [3:0]                color_wmask,
    input  wire logic [IDXW-1:0]           index_wmask,
    input  wire logic                      depth_wmask,
    input  wire logic [SW-1:0]             stencil_wmask,
    output logic                           mem_req,
    output logic                           mem_rd,
    output logic [`FBC_TGT_W-1:0]          mem_tgt,
    output logic [XW-1:0]                  mem_x,
    output logic [XW-1:0]                  mem_y,
    output logic                           mem_draw_all,
    output logic [DBW-1:0]                 mem_draw_idx,
    output logic                           mem_dither,
    output logic [4*CW-1:0]                mem_color_wdata,
    output logic [3:0]                     mem_color_wmask,
    output logic [IDXW-1:0]                mem_index_wmask,
    output logic [DW-1:0]                  mem_depth_wdata,
    output logic                           mem_depth_wmask,
    output logic [SW-1:0]                  mem_stencil_wdata,
    output logic [SW-1:0]                  mem_stencil_wmask,
    output logic [4*`FBC_FX_W-1:0]         mem_accum_wdata,
    input  wire logic                      mem_ack,
    input  wire logic                      pix_owned,
    input  wire logic [4*CW-1:0]           mem_rd_color,
    input  wire logic [4*`FBC_FX_W-1:0]    mem_rd_accum
);
    import fbc_pkg::*;

    localparam int FX   = `FBC_FX_W;
    localparam int FRAC = `FBC_FX_FRAC;
    localparam int HALF = 1 << (FRAC - 1);
    localparam logic signed [FX-1:0] ONE     = `FBC_FX_ONE;
    localparam logic signed [FX-1:0] NEG_ONE = `FBC_FX_NEG_ONE;
    localparam logic signed [FX-1:0] ZERO    = `FBC_FX_ZERO;

    generate
        if (CW < 7 || CW > FRAC || DW < FX || DW > 32 || IDXW > CW || SW > 32 ||
            IDXW + `FBC_IDX_FRAC > 32 || MAX_DRAW < 1 || DBW < 1)
        begin : g_bad_params
            $error("fbc_engine: unsupported parameter values");
        end
    endgenerate

    function automatic logic signed [FX-1:0] fx_sat(input logic signed [31:0] p);
        if (p > `FBC_FX_SAT_HI)
            fx_sat = FX'(`FBC_FX_SAT_HI);
        else if (p < `FBC_FX_SAT_LO)
            fx_sat = FX'(`FBC_FX_SAT_LO);
        else
            fx_sat = FX'(p);
    endfunction

    function automatic logic signed [FX-1:0] fx_mul(input logic signed [FX-1:0] a,
                                                    input logic signed [FX-1:0] b);
        fx_mul = fx_sat((32'(a) * 32'(b)) >>> FRAC);
    endfunction

    function automatic logic signed [FX-1:0] fx_add(input logic signed [FX-1:0] a,
                                                    input logic signed [FX-1:0] b);
        fx_add = fx_sat(32'(a) + 32'(b));
    endfunction

    function automatic logic signed [FX-1:0] fx_clamp(input logic signed [FX-1:0] v,
                                                      input logic signed [FX-1:0] lo,
                                                      input logic signed [FX-1:0] hi);
        fx_clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    // Integer and float results are undefined, so they take the cheapest bits.
    function automatic logic [CW-1:0] to_color(input logic signed [FX-1:0] v,
                                               input fbc_fmt_t f);
        logic signed [31:0] c;
        logic signed [31:0] s;
        c = 32'(fx_clamp(v, (f == FBC_FMT_SNORM) ? NEG_ONE : ZERO, ONE)); // see R8
        unique case (f)
            FBC_FMT_UNORM: s = ((c <<< CW) - c + 32'(HALF)) >>> FRAC;
            FBC_FMT_SNORM: s = ((c <<< (CW - 1)) - c) >>> FRAC;
            FBC_FMT_INT:   s = 32'(v) >>> FRAC;
            FBC_FMT_FLOAT: s = 32'(v) >>> (FX - CW);
        endcase
        to_color = CW'(s);
    endfunction

    // Bit replication stands in for the divide by the full-scale code.
    function automatic logic signed [FX-1:0] unorm_to_fx(input logic [CW-1:0] c);
        logic [31:0] e;
        e = 32'(c);
        unorm_to_fx = FX'((e << (FRAC - CW)) | (e >> (2 * CW - FRAC)));
    endfunction

    function automatic logic [XW:0] span_end(input logic [XW-1:0] st, input logic [XW-1:0] len,
                                             input logic [XW-1:0] win, input logic en);
        logic [XW:0] e;
        e = {1'b0, st} + {1'b0, len};
        span_end = (en && e < {1'b0, win}) ? e : {1'b0, win};
    endfunction

    fbc_state_t               state;
    fbc_state_t               next_state;
    logic signed [FX-1:0]     clr_col [4];
    logic signed [FX-1:0]     acc_clr [4];
    logic signed [FX-1:0]     work_col [4];
    logic signed [FX-1:0]     cmd_c [4];
    logic [IDXW-1:0]          clr_index;
    logic signed [FX-1:0]     clr_depth;
    logic [SW-1:0]            clr_stencil;
    logic signed [FX-1:0]     work_depth;
    logic [SW-1:0]            work_stencil;
    logic signed [FX-1:0]     op_val;
    fbc_acc_op_t              acc_op_q;
    logic                     acc_q;
    logic                     idx_clear_q;
    logic [`FBC_TGT_W-1:0]    tgt;
    logic [`FBC_TGT_W-1:0]    rd_tgt;
    logic [XW:0]              x0;
    logic [XW:0]              x1;
    logic [XW:0]              y1;
    logic [4*FX-1:0]          acc_new;
    logic [4*FX-1:0]          acc_clrw;
    logic [4*CW-1:0]          ret_col;
    logic [4*CW-1:0]          clr_colw;

    assign cmd_c = '{cmd_r, cmd_g, cmd_b, cmd_a};

    wire take      = cmd_valid && cmd_ready;
    wire is_clear  = cmd_op == FBC_CMD_CLEAR;
    wire is_bufcol = cmd_op == FBC_CMD_CLR_BUF_COLOR;
    wire is_pair   = cmd_op == FBC_CMD_CLEAR_DEPTH_STENCIL_PAIR;
    wire is_bufds  = cmd_op inside {FBC_CMD_CLR_BUF_DEPTH, FBC_CMD_CLR_BUF_STENCIL, FBC_CMD_CLEAR_DEPTH_STENCIL_PAIR};
    wire is_acc    = cmd_op == FBC_CMD_ACCUM;
    wire is_ret    = cmd_acc_op == FBC_ACC_RETURN;
    wire idx_bad   = cmd_draw_index[31] || cmd_draw_index >= 32'(MAX_DRAW);
    // Type mismatches between value and storage are never reported. see R13
    wire e_enum    = cmd_op > FBC_CMD_ACCUM || (is_acc && cmd_acc_op > FBC_ACC_ADD);
    wire e_val     = !e_enum && ((is_clear && |(cmd_mask & ~`FBC_MASK_LEGAL))      // see R1
                     || (is_bufcol && idx_bad) || (is_bufds && |cmd_draw_index)); // see R11
    wire e_op      = !e_enum && !e_val && ((is_bufcol && index_mode)               // see R14
                     || (is_acc && (!has_accum || !same_fb || index_mode)));      // see R22
    wire want_c    = (is_clear && cmd_mask[`FBC_MASK_COLOR] && !draw_none) || is_bufcol;
    wire want_d    = (is_clear && cmd_mask[`FBC_MASK_DEPTH]) || cmd_op == FBC_CMD_CLR_BUF_DEPTH
                     || is_pair;                                                   // see R12
    wire want_s    = (is_clear && cmd_mask[`FBC_MASK_STENCIL])
                     || cmd_op == FBC_CMD_CLR_BUF_STENCIL || is_pair;
    // Absent buffers simply drop out of the target set. see R7
    wire t_col     = has_color && (want_c || (is_acc && is_ret && !draw_none));       // see R15
    wire t_acc     = (is_clear && cmd_mask[`FBC_MASK_ACCUM] && has_accum) || (is_acc && !is_ret);
    wire t_dep     = want_d && has_depth;
    wire t_sten    = want_s && has_stencil;
    wire [`FBC_TGT_W-1:0] job_tgt = {t_sten && has_ms, t_dep && has_ms, t_col && has_ms, // see R16
                                     t_sten, t_dep, t_acc, t_col};
    wire [`FBC_TGT_W-1:0] job_rd  = {5'h00, cmd_acc_op != FBC_ACC_LOAD,
                                     cmd_acc_op inside {FBC_ACC_ACCUM, FBC_ACC_LOAD}};
    wire [XW:0]   rx0   = scissor_en ? {1'b0, sc_x} : '0;
    wire [XW:0]   ry0   = scissor_en ? {1'b0, sc_y} : '0;
    wire [XW:0]   rx1   = span_end(sc_x, sc_w, win_w, scissor_en);                  // see R17
    wire [XW:0]   ry1   = span_end(sc_y, sc_h, win_h, scissor_en);
    wire          empty = rx0 >= rx1 || ry0 >= ry1;
    wire          job   = take && !e_enum && !e_val && !e_op && !(cmd_op < FBC_CMD_CLEAR)
                          && |job_tgt && !empty;
    wire          last_x = {1'b0, mem_x} + 1'b1 >= x1;
    wire          last_y = {1'b0, mem_y} + 1'b1 >= y1;
    wire [DW-1:0] depth_fix = DW'(((48'(work_depth) << DW) - 48'(work_depth) + 48'(HALF)) >> FRAC);
    wire [DW-1:0] depth_out = depth_is_float ? DW'(work_depth) : depth_fix;          // see R3
    wire [4*CW-1:0] clr_data = idx_clear_q ? (4*CW)'(clr_index) : clr_colw;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_comp
            wire signed [FX-1:0] rd_acc = mem_rd_accum[gi*FX +: FX];
            wire signed [FX-1:0] rd_col = unorm_to_fx(mem_rd_color[gi*CW +: CW]);     // see R18
            wire signed [FX-1:0] prod   = fx_mul(rd_col, op_val);
            wire signed [FX-1:0] scaled = fx_mul(rd_acc, op_val);
            wire signed [FX-1:0] ret    = frag_clamp_en ? fx_clamp(scaled, ZERO, ONE) : scaled; // see R20
            assign acc_new[gi*FX +: FX] = (acc_op_q == FBC_ACC_LOAD) ? prod               // see R19
                                        : (acc_op_q == FBC_ACC_ACCUM) ? fx_add(rd_acc, prod)
                                        : (acc_op_q == FBC_ACC_OP_SCALE) ? scaled          // see R21
                                        : fx_add(rd_acc, op_val);
            assign ret_col[gi*CW +: CW]  = to_color(ret, color_fmt);
            assign clr_colw[gi*CW +: CW] = to_color(work_col[gi], color_fmt);
            assign acc_clrw[gi*FX +: FX] = acc_clr[gi];
        end
    endgenerate

    // Pixels the context does not own are skipped without a storage access. see R6
    always_comb
    begin
        next_state = state;
        unique case (state)
            FBC_ST_IDLE: next_state = job ? FBC_ST_PIX : FBC_ST_IDLE;
            FBC_ST_PIX:  next_state = !pix_owned ? FBC_ST_NEXT : (acc_q ? FBC_ST_RD : FBC_ST_WR);
            FBC_ST_RD:   next_state = mem_ack ? FBC_ST_WR : FBC_ST_RD;
            FBC_ST_WR:   next_state = mem_ack ? FBC_ST_NEXT : FBC_ST_WR;
            FBC_ST_NEXT: next_state = (last_x && last_y) ? FBC_ST_DONE : FBC_ST_PIX;
            FBC_ST_DONE: next_state = FBC_ST_IDLE;
            default:     next_state = FBC_ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        state         <= rst ? FBC_ST_IDLE : next_state;
        cmd_ready     <= !rst && state == FBC_ST_IDLE && !take;
        done          <= !rst && ((take && !job) || state == FBC_ST_DONE);              // see R23
        err_value     <= !rst && take && e_val;
        err_operation <= !rst && take && e_op;
        err_enum      <= !rst && take && e_enum;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            clr_col     <= '{ZERO, ZERO, ZERO, ZERO};                                  // see R9
            acc_clr     <= '{ZERO, ZERO, ZERO, ZERO};
            clr_index   <= '0;
            clr_depth   <= ONE;
            clr_stencil <= '0;
        end
        else if (take)
        begin
            if (cmd_op == FBC_CMD_SET_COLOR)
                clr_col <= cmd_c;
            if (cmd_op == FBC_CMD_SET_INDEX_CLEAR_VALUE)
                clr_index <= cmd_int[`FBC_IDX_FRAC +: IDXW];                          // see R2
            if (cmd_op == FBC_CMD_SET_DEPTH_CLEAR_VALUE)
                clr_depth <= fx_clamp(cmd_r, ZERO, ONE);                              // see R3
            if (cmd_op == FBC_CMD_SET_STENCIL_CLEAR_VALUE)
                clr_stencil <= cmd_int[SW-1:0];                                       // see R4
            if (cmd_op == FBC_CMD_SET_ACCUMULATOR_CLEAR_VALUE)
                for (int i = 0; i < 4; i++)
                    acc_clr[i] <= fx_clamp(cmd_c[i], NEG_ONE, ONE);                    // see R5
        end
    end

    // Job state is loaded only when a job starts, so it needs no reset.
    always_ff @(posedge sys_clk)
    begin
        if (job)
        begin
            work_col     <= is_bufcol ? cmd_c : clr_col;
            work_depth   <= is_clear ? clr_depth : fx_clamp(cmd_r, ZERO, ONE);        // see R12
            work_stencil <= is_clear ? clr_stencil : cmd_int[SW-1:0];
            idx_clear_q  <= is_clear && index_mode;
            op_val       <= cmd_r;
            acc_op_q     <= cmd_acc_op;
            tgt          <= job_tgt;
            rd_tgt       <= job_rd;
            x0           <= rx0;
            x1           <= rx1;
            y1           <= ry1;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            acc_q <= 1'b0;
        else if (job)
            acc_q <= is_acc;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            mem_x <= '0;
            mem_y <= '0;
        end
        else if (job)
        begin
            mem_x <= rx0[XW-1:0];
            mem_y <= ry0[XW-1:0];
        end
        else if (state == FBC_ST_NEXT && !last_x)
            mem_x <= mem_x + 1'b1;
        else if (state == FBC_ST_NEXT && !last_y)
        begin
            mem_x <= x0[XW-1:0];
            mem_y <= mem_y + 1'b1;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            mem_req           <= 1'b0;
            mem_rd            <= 1'b0;
            mem_tgt           <= '0;
            mem_draw_all      <= 1'b1;
            mem_draw_idx      <= '0;
            mem_dither        <= 1'b0;
            mem_color_wdata   <= '0;
            mem_color_wmask   <= '0;
            mem_index_wmask   <= '0;
            mem_depth_wdata   <= '0;
            mem_depth_wmask   <= 1'b0;
            mem_stencil_wdata <= '0;
            mem_stencil_wmask <= '0;
            mem_accum_wdata   <= '0;
        end
        else if (job)
        begin
            mem_draw_all      <= !is_bufcol;                                           // see R10
            mem_draw_idx      <= cmd_draw_index[DBW-1:0];
            mem_dither        <= dither_en;                                            // see R6
            mem_color_wmask   <= color_wmask;
            mem_index_wmask   <= index_wmask;
            mem_depth_wmask   <= depth_wmask;
            mem_stencil_wmask <= stencil_wmask;
        end
        else if (state == FBC_ST_PIX && pix_owned)
        begin
            mem_req           <= 1'b1;
            mem_rd            <= acc_q;
            mem_tgt           <= acc_q ? rd_tgt : tgt;
            mem_color_wdata   <= clr_data;
            mem_depth_wdata   <= depth_out;
            mem_stencil_wdata <= work_stencil;
            mem_accum_wdata   <= acc_clrw;
        end
        else if (state == FBC_ST_RD && mem_ack)
        begin
            mem_rd            <= 1'b0;
            mem_tgt           <= tgt;
            mem_color_wdata   <= ret_col;
            mem_accum_wdata   <= acc_new;
        end
        else if (state == FBC_ST_WR && mem_ack)
            mem_req <= 1'b0;
    end
endmodule // fbc_engine
`default_nettype wire

// ==== verif/fbc_props.sv ====
// Checker for the command and storage handshakes of the clear engine.
// Assumes it is bound onto fbc_engine; one clock, synchronous reset.
`timescale 1ns/1ns
`default_nettype none
module fbc_props (
    input wire logic sys_clk, rst, cmd_valid, cmd_ready, done,
    input wire logic err_value, err_operation, mem_req, mem_ack, mem_rd
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence s_take; cmd_valid && cmd_ready; endsequence
    sequence s_wait; mem_req && !mem_ack; endsequence
    AST_DONE_PULSE: assert property (done |=> !done) else $error("done too long");
    AST_READY_BACK: assert property (done |=> cmd_ready) else $error("ready late");
    AST_BUSY_LOW: assert property (done |-> !cmd_ready) else $error("ready with done");
    AST_TAKE_BUSY: assert property (s_take |=> !cmd_ready) else $error("ready kept");
    AST_ERRV_DONE: assert property (err_value |-> done) else $error("lone value error");
    AST_ERRO_DONE: assert property (err_operation |-> done) else $error("lone op error");
    AST_MEM_IDLE: assert property (mem_req |-> !cmd_ready && !done) else $error("access idle");
    AST_REQ_HOLD: assert property (s_wait |=> mem_req && $stable(mem_rd)) else $error("req moved");
endmodule // fbc_props
bind fbc_engine fbc_props chk_u (.*);
`default_nettype wire

// ==== verif/fbc_store_model.sv ====
// Storage model: answers at once or after a stall, read data only with ack.
// Assumes the engine holds its request until the ack edge.
`timescale 1ns/1ns
`default_nettype none
module fbc_store_model (
    input wire logic sys_clk, rst, mem_req, slow,
    output logic mem_ack, pix_owned,
    output logic [31:0] mem_rd_color,
    output logic [63:0] mem_rd_accum
);
    logic [1:0] wait_cnt;
    always_ff @(posedge sys_clk)
        wait_cnt <= (rst || !mem_req || mem_ack) ? 2'h0 : wait_cnt + 2'h1;
    assign mem_ack = mem_req && (!slow || wait_cnt == 2'h3);
    assign pix_owned = 1'b1;
    // Data outside the ack cycle is inverted so a stale read cannot match.
    assign mem_rd_color = mem_ack ? 32'hFF00FF00 : 32'h00FF00FF;
    assign mem_rd_accum = mem_ack ? 64'h1000100010001000 : 64'hEFFFEFFFEFFFEFFF;
endmodule // fbc_store_model
`default_nettype wire

// ==== verif/testbench.sv ====
// Self-checking bench for the clear engine on a 3 by 2 window.
// Assumes fbc_engine with default parameters and the storage model.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import fbc_pkg::*;
    logic sys_clk, rst, cmd_valid, cmd_ready, done, err_value, err_operation, err_enum, mem_req;
    logic mem_rd, has_color, has_accum, has_depth, has_stencil, has_ms, depth_is_float, slow;
    logic index_mode, draw_none, same_fb, frag_clamp_en, scissor_en, dither_en, depth_wmask;
    logic mem_ack, pix_owned, mem_draw_all, mem_dither, mem_depth_wmask;
    fbc_cmd_t cmd_op;
    fbc_acc_op_t cmd_acc_op;
    fbc_fmt_t color_fmt;
    logic [31:0] cmd_mask, cmd_draw_index, cmd_int, mem_color_wdata, mem_rd_color;
    logic signed [15:0] cmd_r, cmd_g, cmd_b, cmd_a;
    logic [11:0] sc_x, sc_y, sc_w, sc_h, win_w, win_h, mem_x, mem_y;
    logic [3:0] color_wmask, mem_color_wmask;
    logic [7:0] index_wmask, stencil_wmask, mem_index_wmask, mem_stencil_wdata, mem_stencil_wmask;
    logic [6:0] mem_tgt;
    logic [2:0] mem_draw_idx;
    logic [23:0] mem_depth_wdata;
    logic [63:0] mem_accum_wdata, mem_rd_accum, last_w, last_a;
    int mismatches, checked, writes, cyc;
    fbc_engine dut_u (.*);
    fbc_store_model store_u (.*);
    initial begin sys_clk = 0; forever #2 sys_clk = ~sys_clk; end
    // Captures every write so the walk length and the data can be judged.
    always @(posedge sys_clk) if (mem_req && mem_ack && !mem_rd)
    begin
        writes++;
        last_w = {mem_tgt, mem_stencil_wdata, mem_depth_wdata};
        last_a = mem_accum_wdata;
    end
    always @(posedge sys_clk) if (++cyc == 3000)
    begin
        mismatches++;
        print_verdict();
    end
    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic run(input fbc_cmd_t op, input logic [31:0] m, di, iv, input logic [15:0] v);
        int n;
        while (cmd_ready !== 1'b1) begin @(posedge sys_clk); #1; end
        cmd_op = op;
        {cmd_mask, cmd_draw_index, cmd_int, cmd_r, writes, n} = {m, di, iv, v, 64'h0};
        cmd_valid = 1;
        @(posedge sys_clk); #1;
        cmd_valid = 0;
        while (done !== 1'b1 && n++ < 200) begin @(posedge sys_clk); #1; end
    endtask
    task automatic t_depth_stencil();
        run(FBC_CMD_CLEAR, 4, 0, 0, 0); chk("rst depth", 24'hFFFFFF, last_w[23:0]);
        chk("walk", 6, writes);
        run(FBC_CMD_SET_DEPTH_CLEAR_VALUE, 0, 0, 0, 16'h7FFF);
        run(FBC_CMD_CLEAR, 4, 0, 0, 0); chk("hi depth", 24'hFFFFFF, last_w[23:0]);
        run(FBC_CMD_SET_DEPTH_CLEAR_VALUE, 0, 0, 0, 16'hE000);
        run(FBC_CMD_CLEAR, 4, 0, 0, 0); chk("lo depth", 0, last_w[23:0]);
        run(FBC_CMD_SET_STENCIL_CLEAR_VALUE, 0, 0, 32'h1AB, 0);
        run(FBC_CMD_CLEAR, 8, 0, 0, 0); chk("stencil", 8'hAB, last_w[31:24]);
        run(FBC_CMD_CLEAR_DEPTH_STENCIL_PAIR, 0, 0, 32'h3CD, 0); chk("pair", 8'hCD, last_w[31:24]);
        chk("pair tgt", 2'h3, last_w[35:34]);
        $display("test depth_stencil done");
    endtask
    task automatic t_accum();
        {scissor_en, sc_x, sc_y, sc_w, sc_h, slow} = {1'b1, 12'h1, 12'h1, 12'h5, 12'h5, 1'b1};
        cmd_acc_op = FBC_ACC_OP_SCALE;
        run(FBC_CMD_ACCUM, 0, 0, 0, 16'h2000); chk("box", 2, writes);
        chk("scale", 64'h0800080008000800, last_a);
        cmd_acc_op = FBC_ACC_ADD;
        run(FBC_CMD_ACCUM, 0, 0, 0, 16'h1000); chk("add", 64'h2000200020002000, last_a);
        {scissor_en, slow} = 2'b00;
        $display("test accum done");
    endtask
    task automatic t_errors();
        run(FBC_CMD_CLEAR, 32'h10, 0, 0, 0); chk("mask err", 2'b10, {err_value, err_operation});
        run(FBC_CMD_CLR_BUF_COLOR, 0, 8, 0, 0); chk("idx err", 2'b10, {err_value, writes[0]});
        run(FBC_CMD_CLR_BUF_DEPTH, 0, 1, 0, 0); chk("dep err", 1, err_value);
        index_mode = 1;
        run(FBC_CMD_CLR_BUF_COLOR, 0, 0, 0, 0); chk("ci err", 2'b10, {err_operation, writes[0]});
        {index_mode, same_fb} = 2'b00;
        run(FBC_CMD_ACCUM, 0, 0, 0, 0); chk("acc err", 2'b10, {err_operation, writes[0]});
        {same_fb, has_stencil} = 2'b10;
        run(FBC_CMD_CLEAR, 8, 0, 0, 0); chk("absent", 3'b000, {err_value, err_operation, writes[0]});
        $display("test errors done");
    endtask
    task automatic print_verdict();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        {rst, cmd_valid, slow, has_ms, cmd_g, cmd_b, cmd_a} = {4'h8, 48'h0};
        cmd_acc_op = FBC_ACC_ACCUM;
        color_fmt = FBC_FMT_UNORM;
        cmd_op = FBC_CMD_SET_COLOR;
        {has_color, has_accum, has_depth, has_stencil, same_fb, depth_wmask} = 6'h3F;
        {depth_is_float, index_mode, draw_none, frag_clamp_en, scissor_en, dither_en} = 6'h00;
        {sc_x, sc_y, sc_w, sc_h, win_w, win_h} = {48'h0, 12'h3, 12'h2};
        {color_wmask, index_wmask, stencil_wmask} = 20'hFFFFF;
        {cmd_mask, cmd_draw_index, cmd_int, cmd_r, mismatches, checked, cyc} = 0;
        repeat (3) @(posedge sys_clk);
        #1 rst = 0;
        t_depth_stencil();
        t_accum();
        t_errors();
        print_verdict();
    end
endmodule // testbench
`default_nettype wire
